//--- logic/i2c_status_pkg.sv
// constants for the two-wire status and data path block
// assumes an 8-bit register port and a single 50 MHz clock
package i2c_status_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] OFF_STATUS = 3'h0;
  localparam logic [2:0] OFF_ADDRESS = 3'h1;
  localparam logic [2:0] OFF_TXBUF = 3'h2;
  localparam logic [2:0] OFF_RXBUF = 3'h3;
  localparam logic [2:0] OFF_MODE = 3'h4;
  // status flag positions
  localparam int BIT_TXEMPTY = 7;
  localparam int BIT_RXFULL = 5;
  localparam int BIT_ARBLOST = 2;
  localparam int BIT_AMATCH = 1;
  localparam int BIT_GCALL = 0;
  localparam logic [7:0] FLAG_MASK = 8'ha7;
  // own address register fields
  localparam int BIT_FORMAT = 0;
  // mode register fields
  localparam int BIT_MASTER = 0;
  localparam int BIT_TRANSMIT = 1;
  localparam int BIT_ORDER = 2;
  // reset values
  localparam logic [7:0] BUF_RESET = 8'hff;
  localparam logic [7:0] ADDRESS_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // framing
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [7:0] GENERAL_CALL = 8'h00;
  typedef enum logic [1:0] {LINK_IDLE, LINK_DATA, LINK_ACK} link_state_t;
endpackage

//--- logic/i2c_status_data_path.sv
// status flags, own address, and transmit/receive data path of a two-wire serial port
// assumes scl and sda arrive asynchronously; the serial clock is always made elsewhere
//
// Operation
// [R1] master transmit: data mismatch at clock rise flags loss
// [R2] master: start seen while driving high flags loss
// [R3] synchronous format: last bit while full flags overrun
// [R4] flags clear by reading one, writing zero
// [R5] slave receive: first frame matching address sets flag
// [R6] general call sets general-call and address flags
// [R7] general call only in two-wire slave receive
// [R8] upper seven address bits compared with first frame
// [R9] address bit zero selects two-wire or synchronous format
// [R10] transmit buffer eight bits, read/write, resets ones
// [R11] free shift register loads from transmit buffer
// [R12] byte written during shifting follows without gap
// [R13] bit order select reverses transmit buffer readback
// [R14] receive buffer resets ones, ignores writes
// [R15] completed byte copies into receive buffer
// [R16] shift register hidden from software
// [R17] load into shift register sets transmit-empty
// [R18] copy into receive buffer sets receive-full
// [R19] write one or unarmed zero leaves flag
// [R20] set event beats simultaneous clear
`timescale 1ns/1ps
`default_nettype none
module i2c_status_data_path (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic transmitEmpty,
  output logic receiveFull
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic sclS1;
    logic sclS2;
    logic sclPrev;
    logic sdaS1;
    logic sdaS2;
    logic sdaPrev;
    i2c_status_pkg::link_state_t link;
    logic [3:0] bitCnt;
    logic firstFrame;
    logic selected;
    logic [7:0] shiftRegister;
    logic shiftBusy;
    logic txPending;
    logic sdaLevel;
    logic [7:0] transmitBuffer;
    logic [7:0] receiveBuffer;
    logic [7:0] ownAddressAndFormat;
    logic [7:0] modeRegister;
    logic [7:0] busStatusFlags;
    logic [7:0] armed;
    logic [7:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [7:0] setEv;
  logic [7:0] clrEv;
  logic loadEv;
  logic copyEv;
  logic frameDone;
  logic [7:0] newByte;

  function automatic logic [7:0] reverseBits(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic fmtSync;
  logic isMaster;
  logic isTx;
  logic bitOrder;
  logic [7:0] flags;
  logic txWrite;

  assign sclRise = state_reg.sclS2 & ~state_reg.sclPrev;
  assign sclFall = ~state_reg.sclS2 & state_reg.sclPrev;
  assign startSeen = state_reg.sclS2 & state_reg.sclPrev & state_reg.sdaPrev & ~state_reg.sdaS2;
  assign stopSeen = state_reg.sclS2 & state_reg.sclPrev & ~state_reg.sdaPrev & state_reg.sdaS2;
  assign fmtSync = state_reg.ownAddressAndFormat[i2c_status_pkg::BIT_FORMAT]; // see [R9]
  assign isMaster = state_reg.modeRegister[i2c_status_pkg::BIT_MASTER];
  assign isTx = state_reg.modeRegister[i2c_status_pkg::BIT_TRANSMIT];
  assign bitOrder = state_reg.modeRegister[i2c_status_pkg::BIT_ORDER];
  assign flags = state_reg.busStatusFlags;
  assign txWrite = regWr && (regAddr == i2c_status_pkg::OFF_TXBUF);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    setEv = '0;
    clrEv = '0;
    loadEv = 1'b0;
    copyEv = 1'b0;
    frameDone = 1'b0;
    newByte = {state_reg.shiftRegister[6:0], state_reg.sdaS2};

    // first stage feeds only the second stage
    state_next.sclS1 = sclIn;
    state_next.sclS2 = state_reg.sclS1;
    state_next.sclPrev = state_reg.sclS2;
    state_next.sdaS1 = sdaIn;
    state_next.sdaS2 = state_reg.sdaS1;
    state_next.sdaPrev = state_reg.sdaS2;

    // register writes
    state_next.armed = '0;
    if (regWr) begin
      case (regAddr)
        i2c_status_pkg::OFF_STATUS: begin
          for (int i = 0; i < 8; i++) begin
            // only a zero after a read of one clears; ones are ignored
            if (i2c_status_pkg::FLAG_MASK[i] && !regWdata[i] && state_reg.armed[i]) begin
              clrEv[i] = 1'b1; // see [R4] see [R19]
            end
          end
        end
        i2c_status_pkg::OFF_ADDRESS: state_next.ownAddressAndFormat = regWdata;
        i2c_status_pkg::OFF_TXBUF: begin
          state_next.transmitBuffer = bitOrder ? reverseBits(regWdata) : regWdata; // see [R10] see [R13]
          state_next.txPending = 1'b1; // see [R12]
          clrEv[i2c_status_pkg::BIT_TXEMPTY] = 1'b1;
        end
        i2c_status_pkg::OFF_MODE: state_next.modeRegister = regWdata;
        default: ; // receive buffer is read only, see [R14]
      endcase
    end

    // register reads, data valid in the following cycle only
    state_next.rdata = '0;
    if (regRd) begin
      case (regAddr)
        i2c_status_pkg::OFF_STATUS: begin
          state_next.rdata = flags;
          state_next.armed = flags & i2c_status_pkg::FLAG_MASK;
        end
        i2c_status_pkg::OFF_ADDRESS: state_next.rdata = state_reg.ownAddressAndFormat;
        i2c_status_pkg::OFF_TXBUF: state_next.rdata = state_reg.transmitBuffer;
        i2c_status_pkg::OFF_RXBUF: begin
          state_next.rdata = state_reg.receiveBuffer;
          clrEv[i2c_status_pkg::BIT_RXFULL] = 1'b1;
        end
        i2c_status_pkg::OFF_MODE: state_next.rdata = state_reg.modeRegister;
        default: state_next.rdata = '0; // shift register has no address, see [R16]
      endcase
    end

    // loading never coincides with a shift edge
    if (isTx && state_reg.txPending && !state_reg.shiftBusy && !sclRise) begin
      loadEv = 1'b1; // see [R11] see [R12]
      state_next.shiftRegister = state_reg.transmitBuffer;
      state_next.shiftBusy = 1'b1;
      // a byte written in the load cycle stays queued behind the one loaded
      state_next.txPending = txWrite; // see [R12]
      setEv[i2c_status_pkg::BIT_TXEMPTY] = 1'b1; // see [R17]
    end

    // serial link
    case (state_reg.link)
      i2c_status_pkg::LINK_IDLE: begin
        state_next.sdaLevel = 1'b1;
        state_next.bitCnt = '0;
        if (fmtSync) begin
          state_next.link = i2c_status_pkg::LINK_DATA;
        end
      end
      i2c_status_pkg::LINK_DATA: begin
        if (sclFall) begin
          state_next.sdaLevel = (isTx && state_reg.shiftBusy) ? state_reg.shiftRegister[7] : 1'b1;
        end
        if (sclRise) begin
          // arbitration applies to data bits only; the ack slot is the slave's
          if (!fmtSync && isMaster && isTx && state_reg.sdaLevel != state_reg.sdaS2) begin
            setEv[i2c_status_pkg::BIT_ARBLOST] = 1'b1; // see [R1]
          end
          state_next.shiftRegister = newByte;
          state_next.bitCnt = state_reg.bitCnt + 4'h1;
          if (state_reg.bitCnt == i2c_status_pkg::LAST_BIT) begin
            frameDone = 1'b1;
            state_next.bitCnt = '0;
            state_next.firstFrame = 1'b0;
            state_next.link = fmtSync ? i2c_status_pkg::LINK_DATA : i2c_status_pkg::LINK_ACK;
            if (isTx) begin
              state_next.shiftBusy = 1'b0;
            end else if (fmtSync && flags[i2c_status_pkg::BIT_RXFULL]) begin
              // overrun keeps the unread byte
              setEv[i2c_status_pkg::BIT_ARBLOST] = 1'b1; // see [R3]
            end else if (!fmtSync && !isMaster && state_reg.firstFrame) begin
              if (newByte == i2c_status_pkg::GENERAL_CALL) begin
                setEv[i2c_status_pkg::BIT_GCALL] = 1'b1; // see [R6] see [R7]
                setEv[i2c_status_pkg::BIT_AMATCH] = 1'b1;
                state_next.selected = 1'b1;
                copyEv = 1'b1;
              end else if (newByte[7:1] == state_reg.ownAddressAndFormat[7:1]) begin
                setEv[i2c_status_pkg::BIT_AMATCH] = 1'b1; // see [R5] see [R8]
                state_next.selected = 1'b1;
                copyEv = 1'b1;
              end
            end else if (fmtSync || isMaster || state_reg.selected) begin
              copyEv = 1'b1;
            end
          end
        end
      end
      i2c_status_pkg::LINK_ACK: begin
        if (sclFall) begin
          // acknowledge received bytes when addressed or mastering
          state_next.sdaLevel = !(!isTx && (isMaster || state_next.selected));
        end
        if (sclRise) begin
          state_next.link = i2c_status_pkg::LINK_DATA;
        end
      end
      default: state_next.link = i2c_status_pkg::LINK_IDLE;
    endcase

    if (copyEv) begin
      state_next.receiveBuffer = newByte; // see [R15]
      setEv[i2c_status_pkg::BIT_RXFULL] = 1'b1; // see [R18]
    end

    // start and stop override the bit engine in two-wire format
    if (!fmtSync && startSeen) begin
      if (isMaster && state_reg.sdaLevel) begin
        setEv[i2c_status_pkg::BIT_ARBLOST] = 1'b1; // see [R2]
      end
      state_next.link = i2c_status_pkg::LINK_DATA;
      state_next.bitCnt = '0;
      state_next.firstFrame = 1'b1;
      state_next.selected = 1'b0;
    end else if (!fmtSync && stopSeen) begin
      state_next.link = i2c_status_pkg::LINK_IDLE;
      state_next.selected = 1'b0;
    end
    if (!fmtSync && state_reg.link == i2c_status_pkg::LINK_DATA && state_reg.firstFrame && isMaster) begin
      state_next.selected = 1'b0;
    end

    // set wins over clear
    state_next.busStatusFlags = (flags & ~clrEv) | setEv; // see [R20]
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.sclS1 <= 1'b1;
      state_reg.sclS2 <= 1'b1;
      state_reg.sclPrev <= 1'b1;
      state_reg.sdaS1 <= 1'b1;
      state_reg.sdaS2 <= 1'b1;
      state_reg.sdaPrev <= 1'b1;
      state_reg.sdaLevel <= 1'b1;
      state_reg.link <= i2c_status_pkg::LINK_IDLE;
      state_reg.transmitBuffer <= i2c_status_pkg::BUF_RESET; // see [R10]
      state_reg.receiveBuffer <= i2c_status_pkg::BUF_RESET; // see [R14]
      state_reg.ownAddressAndFormat <= i2c_status_pkg::ADDRESS_RESET;
      state_reg.modeRegister <= i2c_status_pkg::MODE_RESET;
      state_reg.busStatusFlags <= i2c_status_pkg::FLAGS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign regRdata = state_reg.rdata;
  assign sdaOut = 1'b0;
  assign sdaOe = ~state_reg.sdaLevel;
  assign transmitEmpty = flags[i2c_status_pkg::BIT_TXEMPTY];
  assign receiveFull = flags[i2c_status_pkg::BIT_RXFULL];

  ////////////////////////////////////////////////////////////////////////////
  a_arb_data_mismatch: assert property ( // see [R1]
    @(posedge sys_clk) disable iff (sys_rst)
    (!fmtSync && isMaster && isTx && state_reg.link == i2c_status_pkg::LINK_DATA && sclRise
     && state_reg.sdaLevel != state_reg.sdaS2) |=> flags[i2c_status_pkg::BIT_ARBLOST])
    else $error("data mismatch did not flag arbitration loss");

  a_arb_start_high: assert property ( // see [R2]
    @(posedge sys_clk) disable iff (sys_rst)
    (!fmtSync && isMaster && startSeen && state_reg.sdaLevel) |=> flags[i2c_status_pkg::BIT_ARBLOST])
    else $error("start while released did not flag arbitration loss");

  a_overrun_keeps_byte: assert property ( // see [R3]
    @(posedge sys_clk) disable iff (sys_rst)
    (fmtSync && !isTx && frameDone && flags[i2c_status_pkg::BIT_RXFULL])
    |=> flags[i2c_status_pkg::BIT_ARBLOST] && $stable(state_reg.receiveBuffer))
    else $error("overrun not flagged or buffer overwritten");

  a_flag_holds_set: assert property ( // see [R4] see [R19]
    @(posedge sys_clk) disable iff (sys_rst)
    (flags[i2c_status_pkg::BIT_ARBLOST] && !(regWr && regAddr == i2c_status_pkg::OFF_STATUS
     && !regWdata[i2c_status_pkg::BIT_ARBLOST] && state_reg.armed[i2c_status_pkg::BIT_ARBLOST]))
    |=> flags[i2c_status_pkg::BIT_ARBLOST])
    else $error("flag cleared without read-one write-zero");

  a_flag_set_wins: assert property ( // see [R20]
    @(posedge sys_clk) disable iff (sys_rst)
    (setEv[i2c_status_pkg::BIT_TXEMPTY] && clrEv[i2c_status_pkg::BIT_TXEMPTY])
    |=> transmitEmpty)
    else $error("clear beat a simultaneous set");

  a_address_match: assert property ( // see [R5] see [R8]
    @(posedge sys_clk) disable iff (sys_rst)
    (!fmtSync && !isMaster && !isTx && state_reg.firstFrame && frameDone
     && newByte[7:1] == state_reg.ownAddressAndFormat[7:1])
    |=> flags[i2c_status_pkg::BIT_AMATCH] ##1 flags[i2c_status_pkg::BIT_RXFULL])
    else $error("own address not recognised");

  a_general_call: assert property ( // see [R6] see [R7]
    @(posedge sys_clk) disable iff (sys_rst)
    (setEv[i2c_status_pkg::BIT_GCALL]) |-> (!fmtSync && !isMaster && !isTx)
    ##1 (flags[i2c_status_pkg::BIT_GCALL] && flags[i2c_status_pkg::BIT_AMATCH]))
    else $error("general call flags wrong");

  a_tx_readback: assert property ( // see [R13]
    @(posedge sys_clk) disable iff (sys_rst)
    (regWr && regAddr == i2c_status_pkg::OFF_TXBUF && bitOrder)
    |=> state_reg.transmitBuffer == reverseBits($past(regWdata)))
    else $error("transmit buffer not bit reversed");

  a_rx_write_ignored: assert property ( // see [R14]
    @(posedge sys_clk) disable iff (sys_rst)
    (regWr && regAddr == i2c_status_pkg::OFF_RXBUF && !copyEv) |=> $stable(state_reg.receiveBuffer))
    else $error("write changed receive buffer");

  a_tx_back_to_back: assert property ( // see [R11] see [R12] see [R17]
    @(posedge sys_clk) disable iff (sys_rst)
    (isTx && state_reg.txPending && !state_reg.shiftBusy && !sclRise)
    |=> state_reg.shiftBusy && state_reg.txPending == $past(txWrite) && transmitEmpty
        && state_reg.shiftRegister == $past(state_reg.transmitBuffer))
    else $error("pending byte not loaded into shift register");

  a_rx_copy: assert property ( // see [R15] see [R18]
    @(posedge sys_clk) disable iff (sys_rst)
    (copyEv) |=> receiveFull && state_reg.receiveBuffer == $past(newByte))
    else $error("received byte not copied");

  a_address_miss: assert property ( // see [R5] see [R8]
    @(posedge sys_clk) disable iff (sys_rst)
    (!fmtSync && !isMaster && !isTx && state_reg.firstFrame && frameDone && !flags[i2c_status_pkg::BIT_AMATCH]
     && newByte != i2c_status_pkg::GENERAL_CALL && newByte[7:1] != state_reg.ownAddressAndFormat[7:1])
    |=> !flags[i2c_status_pkg::BIT_AMATCH])
    else $error("foreign address recognised");

  a_tx_queued: assert property ( // see [R10] see [R12]
    @(posedge sys_clk) disable iff (sys_rst)
    (txWrite && !bitOrder) |=> state_reg.txPending && state_reg.transmitBuffer == $past(regWdata))
    else $error("written byte not queued");

endmodule
`default_nettype wire

//--- verification/i2c_bus_partner.sv
// partner on the two-wire bus: another master or slave, open drain with pull-up
// assumes the bench resolves the wire from every pull and feeds it back as sdaWire
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner (
  input wire logic clk,
  input wire logic sdaWire,
  output logic sclLine,
  output logic pullLow
);
  // idle bus: clock parked high, data released to the pull-up
  initial begin
    sclLine = 1'b1;
    pullLow = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // quarter of the 160 ns link period
  task automatic qtr();
    repeat (2) @(posedge clk);
  endtask
  task automatic start_cond();
    pullLow <= 1'b1;
    qtr();
    qtr();
    sclLine <= 1'b0;
    qtr();
  endtask
  task automatic stop_cond();
    sclLine <= 1'b0;
    qtr();
    pullLow <= 1'b1;
    qtr();
    sclLine <= 1'b1;
    qtr();
    pullLow <= 1'b0;
    qtr();
  endtask
  ////////////////////////////////////////////////////////////////////////
  // bits[8:1] data, bits[0] ninth-clock level; a 1 releases the line
  // data moves only while the clock is low, so no false start or stop
  task automatic frame(input logic [8:0] bits, input int nclk, output logic [7:0] got);
    for (int i = 0; i < nclk; i++) begin
      sclLine <= 1'b0;
      qtr();
      pullLow <= ~bits[8 - i];
      qtr();
      sclLine <= 1'b1;
      qtr();
      qtr();
      if (i < 8) begin
        got[7 - i] = sdaWire;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- verification/i2c_status_address_data_path_tb.sv
// self-checking bench for the status, address and data path block
// assumes the bus partner model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
module i2c_status_address_data_path_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic sdaOut, sdaOe, transmitEmpty, receiveFull, sclLine, pullLow;
  wire logic sdaWire;
  int failures = 0;
  int samplesChecked = 0;
  int seed = 30388;
  // open drain: pulled up unless either side pulls low
  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~pullLow;
  always #10 sys_clk = ~sys_clk;
  i2c_status_data_path i2c_status_data_path_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclLine), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .transmitEmpty(transmitEmpty), .receiveFull(receiveFull));
  i2c_bus_partner i2c_bus_partner_inst (.clk(sys_clk), .sdaWire(sdaWire), .sclLine(sclLine), .pullLow(pullLow));
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    samplesChecked++;
    if (seen !== expv) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] expv);
    logic [7:0] d;
    rd(a, d);
    chk(d & mask, expv);
  endtask
  // arm by reading, then zero only the chosen bits; arming lasts one cycle, so no gap
  task automatic clr(input logic [7:0] mask);
    @(posedge sys_clk);
    regAddr <= i2c_status_pkg::OFF_STATUS;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    regWdata <= ~mask;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev[i] = v[7 - i];
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end
  initial begin
    logic [7:0] b1, b2, got, adr;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdchk(i2c_status_pkg::OFF_STATUS, 8'hff, 8'h00);
    rdchk(i2c_status_pkg::OFF_ADDRESS, 8'hff, 8'h00);
    rdchk(i2c_status_pkg::OFF_TXBUF, 8'hff, 8'hff);
    wr(i2c_status_pkg::OFF_RXBUF, 8'h5a);
    rdchk(i2c_status_pkg::OFF_RXBUF, 8'hff, 8'hff);
    rdchk(3'h6, 8'hff, 8'h00);
    $display("test reset done");
    // master transmit, second byte queued while the first shifts
    wr(i2c_status_pkg::OFF_ADDRESS, 8'ha4);
    wr(i2c_status_pkg::OFF_MODE, 8'h03);
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    wr(i2c_status_pkg::OFF_TXBUF, b1);
    i2c_bus_partner_inst.start_cond();
    rdchk(i2c_status_pkg::OFF_STATUS, 8'h84, 8'h84);
    wr(i2c_status_pkg::OFF_TXBUF, b2);
    i2c_bus_partner_inst.frame({8'hff, 1'b0}, 9, got);
    chk(got, b1);
    i2c_bus_partner_inst.frame({8'hff, 1'b0}, 9, got);
    chk(got, b2);
    clr(8'h04);
    rdchk(i2c_status_pkg::OFF_STATUS, 8'h04, 8'h00);
    wr(i2c_status_pkg::OFF_TXBUF, b1 | 8'h80);
    i2c_bus_partner_inst.frame({8'h00, 1'b0}, 9, got);
    rdchk(i2c_status_pkg::OFF_STATUS, 8'h04, 8'h04);
    i2c_bus_partner_inst.stop_cond();
    $display("test master transmit done");
    // two writes back to back with the shifter idle: the second meets the load
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    @(posedge sys_clk);
    regAddr <= i2c_status_pkg::OFF_TXBUF;
    regWdata <= b1;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWdata <= b2;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
    chk({7'h00, transmitEmpty}, 8'h01);
    rdchk(i2c_status_pkg::OFF_TXBUF, 8'hff, b2);
    wr(i2c_status_pkg::OFF_STATUS, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({7'h00, transmitEmpty}, 8'h01);
    clr(8'h80);
    repeat (2) @(posedge sys_clk);
    chk({7'h00, transmitEmpty}, 8'h00);
    rdchk(i2c_status_pkg::OFF_STATUS, 8'h04, 8'h04);
    wr(i2c_status_pkg::OFF_MODE, 8'h04);
    b1 = 8'($random(seed));
    wr(i2c_status_pkg::OFF_TXBUF, b1);
    rdchk(i2c_status_pkg::OFF_TXBUF, 8'hff, rev(b1));
    $display("test flags done");
    // slave receive: a near-miss address, then the own address, then general call
    adr = (8'($random(seed)) | 8'h02) & 8'hfe;
    wr(i2c_status_pkg::OFF_ADDRESS, adr);
    wr(i2c_status_pkg::OFF_MODE, 8'h00);
    for (int k = 0; k < 3; k++) begin
      b1 = (k == 0) ? (adr ^ 8'h80) : ((k == 1) ? adr : 8'h00);
      i2c_bus_partner_inst.start_cond();
      i2c_bus_partner_inst.frame({b1, 1'b1}, 9, got);
      i2c_bus_partner_inst.stop_cond();
      rdchk(i2c_status_pkg::OFF_STATUS, 8'h23, (k == 0) ? 8'h00 : ((k == 1) ? 8'h22 : 8'h23));
      if (k > 0) begin
        rdchk(i2c_status_pkg::OFF_RXBUF, 8'hff, b1);
        repeat (2) @(posedge sys_clk);
        chk({7'h00, receiveFull}, 8'h00);
        clr(8'h07);
      end
    end
    $display("test slave receive done");
    // synchronous format: general call value means nothing, second byte overruns
    wr(i2c_status_pkg::OFF_ADDRESS, adr | 8'h01);
    rdchk(i2c_status_pkg::OFF_ADDRESS, 8'hff, adr | 8'h01);
    i2c_bus_partner_inst.frame({8'h00, 1'b1}, 8, got);
    rdchk(i2c_status_pkg::OFF_STATUS, 8'h25, 8'h20);
    b2 = 8'($random(seed));
    i2c_bus_partner_inst.frame({b2, 1'b1}, 8, got);
    rdchk(i2c_status_pkg::OFF_STATUS, 8'h04, 8'h04);
    rdchk(i2c_status_pkg::OFF_RXBUF, 8'hff, 8'h00);
    $display("test synchronous done");
    report_and_stop();
  end
endmodule
`default_nettype wire
